// ==== include/pdcm_pkg.sv ====
`default_nettype none
package pdcm_pkg;
    // Alternate-space identifiers.
    localparam logic [7:0] ASI_MMU_OP   = 8'h03;
    localparam logic [7:0] ASI_DIAG_ONE = 8'h06;
    localparam logic [7:0] ASI_DIAG_ALT = 8'h05;
    // Operation address fields.
    localparam int OP_PAGE_MSB = 31;
    localparam int OP_PAGE_LSB = 12;
    localparam int OP_TYPE_MSB = 11;
    localparam int OP_TYPE_LSB = 8;
    localparam int SEG_LSB     = 18;
    localparam int REG_LSB     = 24;
    // Operation type codes, shared by flush and probe.
    localparam logic [3:0] OP_PAGE    = 4'h0;
    localparam logic [3:0] OP_SEGMENT = 4'h1;
    localparam logic [3:0] OP_REGION  = 4'h2;
    localparam logic [3:0] OP_CONTEXT = 4'h3;
    localparam logic [3:0] OP_ENTIRE  = 4'h4;
    // Entry field positions.
    localparam int MOD_BIT      = 6;
    localparam int REF_BIT      = 5;
    localparam int PERM_MSB     = 4;
    localparam int PERM_LSB     = 2;
    localparam int KIND_MSB     = 1;
    localparam int KIND_LSB     = 0;
    localparam int PTR_LSB      = 2;
    // Entry kinds.
    localparam logic [1:0] KIND_INVALID  = 2'h0;
    localparam logic [1:0] KIND_POINTER  = 2'h1;
    localparam logic [1:0] KIND_ENTRY    = 2'h2;
    localparam logic [1:0] KIND_RESERVED = 2'h3;
    // Permission codes 6 and 7 are shared across contexts.
    localparam logic [2:0] PERM_SHARED_MIN = 3'h6;
    // Levels of the table walk.
    localparam logic [1:0] LEVEL_0 = 2'h0;
    localparam logic [1:0] LEVEL_3 = 2'h3;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
    typedef enum logic [2:0]
    {
        PDCM_IDLE   = 3'b000,
        PDCM_READ   = 3'b001,
        PDCM_WAIT   = 3'b011,
        PDCM_WRITE  = 3'b010,
        PDCM_WWAIT  = 3'b110,
        PDCM_DONE   = 3'b111
    } pdcm_state_type;
endpackage
`default_nettype wire

// ==== rtl/pdcm_maint.sv ====
`timescale 1ns/1ps
`default_nettype none
module pdcm_maint
    import pdcm_pkg::*;
#(
    parameter int ENTRIES = 8,
    parameter int CTX_W   = 8
)
(
    // Clock and reset.
    input  wire logic              clk_i,
    input  wire logic              reset_i,
    // Current context.
    input  wire logic [CTX_W-1:0]  context_id_i,
    // Alternate-space request from the integer unit.
    input  wire logic              req_valid_i,
    input  wire logic              req_write_i,
    input  wire logic [7:0]        req_asi_i,
    input  wire logic [31:0]       req_addr_i,
    input  wire logic [31:0]       req_wdata_i,
    output logic                   req_ready_o,
    output logic                   resp_valid_o,
    output logic [31:0]            resp_data_o,
    // Translation report: a successful lookup and its cache slot.
    input  wire logic              xlate_valid_i,
    input  wire logic              xlate_write_i,
    input  wire logic [$clog2(ENTRIES)-1:0] xlate_slot_i,
    output logic                   xlate_hold_o,
    // Fill from the translation walker.
    input  wire logic              fill_valid_i,
    input  wire logic [$clog2(ENTRIES)-1:0] fill_slot_i,
    input  wire logic [31:0]       fill_entry_i,
    input  wire logic [31:0]       fill_addr_i,
    input  wire logic [31:0]       fill_paddr_i,
    input  wire logic [1:0]        fill_level_i,
    // Cached state seen by the translation path.
    output logic [ENTRIES-1:0]     slot_valid_o,
    // Memory port to the page tables; lock keeps updates atomic.
    output logic                   mem_req_o,
    output logic                   mem_we_o,
    output logic                   mem_lock_o,
    output logic [31:0]            mem_addr_o,
    output logic [31:0]            mem_wdata_o,
    input  wire logic              mem_ack_i,
    input  wire logic [31:0]       mem_rdata_i,
    input  wire logic              uncorrectable_fault_i,
    input  wire logic              expired_wait_fault_i,
    input  wire logic              bus_fault_i,
    // Table root for the current context.
    input  wire logic [31:0]       root_paddr_i
);
    localparam int SW = $clog2(ENTRIES);
    // Slot numbers are cut straight from address bits, so the depth must be a power of two.
    if (ENTRIES < 2 || (ENTRIES & (ENTRIES - 1)) != 0 || CTX_W < 1 || CTX_W > 16)
    begin : g_bad_params
        $error("pdcm_maint: unsupported parameters");
    end

    // ----------------------------------------------------------------
    // Cache storage
    // ----------------------------------------------------------------
    logic [31:0]      ent_q   [ENTRIES];
    logic [31:0]      tag_q   [ENTRIES];
    logic [31:0]      paddr_q [ENTRIES];
    logic [1:0]       lvl_q   [ENTRIES];
    logic [CTX_W-1:0] ctx_q   [ENTRIES];
    logic [ENTRIES-1:0] valid_q;

    function automatic logic prefix_eq(input logic [31:0] a, input logic [31:0] b,
                                       input logic [1:0] lvl);
        // Compare the bits that select a table at the given depth.
        case (lvl)
            2'd1:    prefix_eq = a[31:REG_LSB] == b[31:REG_LSB];
            2'd2:    prefix_eq = a[31:SEG_LSB] == b[31:SEG_LSB];
            2'd3:    prefix_eq = a[31:OP_PAGE_LSB] == b[31:OP_PAGE_LSB];
            default: prefix_eq = 1'b1;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // Flush match
    // ----------------------------------------------------------------
    logic is_mmu_op;
    logic is_diag;
    logic [3:0] op_type;
    logic [ENTRIES-1:0] flush_hit;
    assign is_mmu_op = req_asi_i == ASI_MMU_OP;
    assign is_diag   = req_asi_i == ASI_DIAG_ONE || req_asi_i == ASI_DIAG_ALT;
    assign op_type   = req_addr_i[OP_TYPE_MSB:OP_TYPE_LSB];

    always_comb
    begin
        for (int i = 0; i < ENTRIES; i++)
        begin
            logic ptr;
            logic shared;
            logic own;
            logic guard;
            ptr    = ent_q[i][KIND_MSB:KIND_LSB] == KIND_POINTER;
            shared = ent_q[i][PERM_MSB:PERM_LSB] >= PERM_SHARED_MIN;
            own    = ctx_q[i] == context_id_i;
            guard  = ptr || shared || own;
            case (op_type)
                OP_PAGE:    flush_hit[i] = lvl_q[i] == LEVEL_3 && guard &&
                                           prefix_eq(tag_q[i], req_addr_i, 2'd3);
                OP_SEGMENT: flush_hit[i] = lvl_q[i] >= 2'd2 && guard &&
                                           prefix_eq(tag_q[i], req_addr_i, 2'd2);
                OP_REGION:  flush_hit[i] = lvl_q[i] >= 2'd1 && guard &&
                                           prefix_eq(tag_q[i], req_addr_i, 2'd1);
                // Pointers are also dropped here; over-flushing is harmless.
                OP_CONTEXT: flush_hit[i] = ptr || (!shared && own);
                OP_ENTIRE:  flush_hit[i] = 1'b1;
                default:    flush_hit[i] = 1'b0;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Sequencer: probe walk and referenced/modified write-back
    // ----------------------------------------------------------------
    pdcm_state_type state_q;
    logic        probe_q;
    logic [3:0]  ptype_q;
    logic [31:0] va_q;
    logic [1:0]  lvl_w_q;
    logic [31:0] word_q;
    logic [SW-1:0] uslot_q;
    logic        resp_q;
    logic [31:0] rdata_q;
    logic [31:0] mem_addr_q;
    logic        fault;
    logic        start_update;
    logic        start_req;
    logic [31:0] upd_word;
    logic [1:0]  rd_kind;
    logic        at_target;

    assign fault = uncorrectable_fault_i || expired_wait_fault_i || bus_fault_i;
    assign rd_kind = mem_rdata_i[KIND_MSB:KIND_LSB];
    // A probe of type n stops at level 3-n; entire walks on, and reserved types answer zero after the first read.
    assign at_target = ptype_q < OP_ENTIRE && ptype_q[1:0] == (LEVEL_3 - lvl_w_q);
    assign upd_word = ent_q[xlate_slot_i] | (32'h0000_0001 << REF_BIT)
                      | ({31'h0000_0000, xlate_write_i} << MOD_BIT);
    assign start_update = state_q == PDCM_IDLE && xlate_valid_i &&
                          (!ent_q[xlate_slot_i][REF_BIT] ||
                           (xlate_write_i && !ent_q[xlate_slot_i][MOD_BIT]));
    assign start_req = state_q == PDCM_IDLE && !start_update && req_valid_i;
    // The store stalls until its modified bit is in memory, and while a walk is busy,
    // since a translation reported then could not start its own update.
    assign xlate_hold_o = start_update || state_q != PDCM_IDLE;
    assign req_ready_o  = start_req && (req_write_i || !is_mmu_op);

    function automatic logic [31:0] walk_addr(input logic [31:0] base, input logic [31:0] va,
                                              input logic [1:0] lvl);
        case (lvl)
            2'd1:    walk_addr = base + {22'h00_0000, va[31:24], 2'b00};
            2'd2:    walk_addr = base + {24'h00_0000, va[23:18], 2'b00};
            2'd3:    walk_addr = base + {24'h00_0000, va[17:12], 2'b00};
            default: walk_addr = base + (32'(context_id_i) << 2);
        endcase
    endfunction

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            state_q    <= PDCM_IDLE;
            probe_q    <= 1'b0;
            ptype_q    <= 4'h0;
            va_q       <= ZERO_WORD;
            lvl_w_q    <= LEVEL_0;
            word_q     <= ZERO_WORD;
            uslot_q    <= '0;
            resp_q     <= 1'b0;
            rdata_q    <= ZERO_WORD;
            mem_addr_q <= ZERO_WORD;
        end
        else
        begin
            resp_q <= 1'b0;
            case (state_q)
                PDCM_IDLE:
                begin
                    if (start_update)
                    begin
                        probe_q    <= 1'b0;
                        uslot_q    <= xlate_slot_i;
                        word_q     <= upd_word;
                        mem_addr_q <= paddr_q[xlate_slot_i];
                        state_q    <= PDCM_WRITE;
                    end
                    else if (start_req && !req_write_i && is_mmu_op)
                    begin
                        probe_q    <= 1'b1;
                        ptype_q    <= op_type;
                        va_q       <= req_addr_i;
                        lvl_w_q    <= LEVEL_0;
                        mem_addr_q <= walk_addr(root_paddr_i, req_addr_i, LEVEL_0);
                        state_q    <= PDCM_READ;
                    end
                    else if (start_req && !req_write_i)
                    begin
                        resp_q  <= 1'b1;
                        rdata_q <= is_diag ? ent_q[req_addr_i[SW+1:2]] : ZERO_WORD;
                    end
                end
                PDCM_READ:
                    state_q <= PDCM_WAIT;
                PDCM_WAIT:
                begin
                    if (mem_ack_i)
                    begin
                        state_q <= PDCM_DONE;
                        resp_q  <= 1'b1;
                        rdata_q <= ZERO_WORD;
                        if (fault)
                            rdata_q <= ZERO_WORD;
                        else if (ptype_q > OP_ENTIRE)
                            rdata_q <= ZERO_WORD;
                        else if (at_target)
                            rdata_q <= (rd_kind == KIND_POINTER && lvl_w_q == LEVEL_3) ? ZERO_WORD
                                       : (rd_kind == KIND_RESERVED ? ZERO_WORD : mem_rdata_i);
                        else if (rd_kind == KIND_ENTRY)
                            rdata_q <= ptype_q == OP_ENTIRE ? mem_rdata_i : ZERO_WORD;
                        else if (rd_kind == KIND_POINTER && lvl_w_q != LEVEL_3)
                        begin
                            resp_q     <= 1'b0;
                            lvl_w_q    <= lvl_w_q + 2'd1;
                            mem_addr_q <= walk_addr({mem_rdata_i[31:PTR_LSB], 2'b00} << 4,
                                                    va_q, lvl_w_q + 2'd1);
                            state_q    <= PDCM_READ;
                        end
                        else
                            rdata_q <= ZERO_WORD;
                    end
                end
                PDCM_WRITE:
                    state_q <= PDCM_WWAIT;
                PDCM_WWAIT:
                    if (mem_ack_i)
                        state_q <= PDCM_DONE;
                PDCM_DONE:
                    state_q <= PDCM_IDLE;
                default:
                    state_q <= PDCM_IDLE;
            endcase
        end
    end

    assign resp_valid_o = resp_q;
    assign resp_data_o  = rdata_q;
    assign mem_req_o    = state_q == PDCM_READ || state_q == PDCM_WRITE;
    assign mem_we_o     = state_q == PDCM_WRITE || state_q == PDCM_WWAIT;
    // Only the write of an update is locked; probe reads never lock.
    assign mem_lock_o   = !probe_q && (state_q == PDCM_WRITE || state_q == PDCM_WWAIT);
    assign mem_addr_o   = mem_addr_q;
    assign mem_wdata_o  = word_q;

    // ----------------------------------------------------------------
    // Cache update: fill, flush, diagnostic write, bit update
    // ----------------------------------------------------------------
    logic flush_go;
    logic diag_go;
    assign flush_go = req_ready_o && req_write_i && is_mmu_op;
    assign diag_go  = req_ready_o && req_write_i && is_diag;

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            valid_q <= '0;
        else
        begin
            if (flush_go)
                valid_q <= valid_q & ~flush_hit;
            if (fill_valid_i)
                valid_q[fill_slot_i] <= 1'b1;
            if (diag_go)
                valid_q[req_addr_i[SW+1:2]] <= 1'b1;
        end
    end

    always_ff @(posedge clk_i)
    begin
        // A fill in another slot must not swallow the cached bit update.
        if (start_update)
            ent_q[xlate_slot_i] <= upd_word;
        if (diag_go)
            ent_q[req_addr_i[SW+1:2]] <= req_wdata_i;
        if (fill_valid_i)
        begin
            ent_q[fill_slot_i]   <= fill_entry_i;
            tag_q[fill_slot_i]   <= fill_addr_i;
            paddr_q[fill_slot_i] <= fill_paddr_i;
            lvl_q[fill_slot_i]   <= fill_level_i;
            ctx_q[fill_slot_i]   <= context_id_i;
        end
    end

    assign slot_valid_o = valid_q;
endmodule
`default_nettype wire

// ==== verif/pdcm_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
module pdcm_checker
    import pdcm_pkg::*;
#(
    parameter int ENTRIES = 8
)
(
    // Clock and reset.
    input wire logic               clk_i,
    input wire logic               reset_i,
    // Request side.
    input wire logic               req_valid_i,
    input wire logic               req_write_i,
    input wire logic [7:0]         req_asi_i,
    input wire logic [31:0]        req_addr_i,
    input wire logic               req_ready_o,
    input wire logic               resp_valid_o,
    input wire logic [31:0]        resp_data_o,
    // Cache and memory side.
    input wire logic               fill_valid_i,
    input wire logic [ENTRIES-1:0] slot_valid_o,
    input wire logic               mem_req_o,
    input wire logic               mem_we_o,
    input wire logic               mem_lock_o,
    input wire logic [31:0]        mem_wdata_o,
    input wire logic               mem_ack_i,
    input wire logic               bus_fault_i
);
    // ------
    // Properties
    // ------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    logic take;
    assign take = req_valid_i && req_write_i && req_ready_o && req_asi_i == ASI_MMU_OP && !fill_valid_i;
    property p_resp_pulse; resp_valid_o |=> !resp_valid_o; endproperty
    property p_entire; take && req_addr_i[11:8] == OP_ENTIRE |=> slot_valid_o == '0; endproperty
    property p_reserved; take && req_addr_i[11:8] > OP_ENTIRE |=> $stable(slot_valid_o); endproperty
    property p_busy; mem_req_o |-> !req_ready_o; endproperty
    property p_ref; mem_req_o && mem_we_o |-> mem_wdata_o[REF_BIT]; endproperty
    property p_lock; mem_req_o && mem_we_o |-> mem_lock_o; endproperty
    property p_fault; mem_ack_i && bus_fault_i && !mem_lock_o |=> resp_valid_o && resp_data_o == ZERO_WORD; endproperty
    property p_load; req_valid_i && !req_write_i && req_ready_o |=> resp_valid_o; endproperty
    a_resp_pulse: assert property (p_resp_pulse) else $error("response longer than one cycle");
    a_entire: assert property (p_entire) else $error("entire flush left slots");
    a_reserved: assert property (p_reserved) else $error("reserved flush changed slots");
    a_busy: assert property (p_busy) else $error("request taken while busy");
    a_ref: assert property (p_ref) else $error("update without referenced bit");
    a_lock: assert property (p_lock) else $error("update write not locked");
    a_fault: assert property (p_fault) else $error("faulted probe not zero");
    a_load: assert property (p_load) else $error("load without response");
    c_entire: cover property (take && req_addr_i[11:8] == OP_ENTIRE);
    c_resp: cover property (resp_valid_o && resp_data_o != ZERO_WORD);
    c_update: cover property (mem_req_o && mem_we_o);
endmodule
`default_nettype wire

// ==== verif/pdcm_mem_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module pdcm_mem_model
(
    // Clock, reset, pacing and fault selection.
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    input  wire logic        slow_i,
    input  wire logic [1:0]  fault_sel_i,
    // Page table port.
    input  wire logic        req_i,
    input  wire logic        we_i,
    input  wire logic [31:0] addr_i,
    input  wire logic [31:0] wdata_i,
    output logic             ack_o = 1'b0,
    output logic [31:0]      rdata_o = 32'h0000_0000,
    output logic [2:0]       faults_o = 3'b000
);
    // ------
    // Memory
    // ------
    logic [31:0] mem [logic [31:0]];
    logic [31:0] addr_q;
    logic [31:0] data_q;
    logic        we_q;
    int          wait_q = 0;
    // Read data toggles outside an answer so stale values never look valid.
    always @(posedge clk_i)
    begin
        ack_o <= 1'b0;
        faults_o <= 3'b000;
        rdata_o <= ~rdata_o;
        if (reset_i)
            wait_q <= 0;
        else if (req_i)
        begin
            addr_q <= addr_i;
            we_q <= we_i;
            data_q <= wdata_i;
            wait_q <= slow_i ? 4 : 1;
        end
        else if (wait_q == 1)
        begin
            ack_o <= 1'b1;
            wait_q <= 0;
            if (we_q)
                mem[addr_q] = data_q;
            else
                rdata_o <= mem.exists(addr_q) ? mem[addr_q] : 32'h0000_0000;
            if (!we_q && fault_sel_i != 2'b00)
                faults_o <= 3'b001 << (fault_sel_i - 2'b01);
        end
        else if (wait_q > 1)
            wait_q <= wait_q - 1;
    end
endmodule
`default_nettype wire

// ==== verif/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
bind pdcm_maint pdcm_checker #(.ENTRIES(ENTRIES)) u_pdcm_checker (.*);
module tb;
    import pdcm_pkg::*;
    localparam int ENTRIES = 8;
    logic clk_i = 1'b0, reset_i = 1'b1, req_valid_i = 1'b0, req_write_i = 1'b0;
    logic xlate_valid_i = 1'b0, xlate_write_i = 1'b0, fill_valid_i = 1'b0, slow = 1'b0;
    logic [7:0] context_id_i = 8'h01, req_asi_i = 8'h00;
    logic [31:0] req_addr_i = '0, req_wdata_i = '0, fill_entry_i = '0, fill_addr_i = '0, fill_paddr_i = '0;
    logic [31:0] root_paddr_i = 32'h0000_1000, resp_data_o, mem_addr_o, mem_wdata_o, mem_rdata_i, d, a, go;
    logic [2:0] xlate_slot_i = '0, fill_slot_i = '0, spm [8];
    logic [1:0] fill_level_i = '0, fault_sel = '0, slv [8], skd [8];
    logic req_ready_o, resp_valid_o, xlate_hold_o, mem_req_o, mem_we_o, mem_lock_o, mem_ack_i;
    wire uncorrectable_fault_i, expired_wait_fault_i, bus_fault_i;
    logic [ENTRIES-1:0] slot_valid_o;
    logic [31:0] sva [8], pexp [6], l1a, l3a;
    logic [7:0] sctx [8];
    int fails = 0;
    int n_checks = 0;
    pdcm_maint #(.ENTRIES(ENTRIES), .CTX_W(8)) u_pdcm_maint (.*);
    pdcm_mem_model u_pdcm_mem_model (.clk_i(clk_i), .reset_i(reset_i), .slow_i(slow), .fault_sel_i(fault_sel),
        .req_i(mem_req_o), .we_i(mem_we_o), .addr_i(mem_addr_o), .wdata_i(mem_wdata_o), .ack_o(mem_ack_i),
        .rdata_o(mem_rdata_i), .faults_o({bus_fault_i, expired_wait_fault_i, uncorrectable_fault_i}));
    // ------
    // Tasks
    // ------
    initial forever #20 clk_i = ~clk_i;
    task automatic test_done;
        if (fails == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Requests are held until the design's own answer, then a quiet cycle follows.
    task automatic op(input logic w, input logic [7:0] asi, input logic [31:0] ad, output logic [31:0] q);
        int   i;
        logic pr;
        pr = !w && asi == ASI_MMU_OP;
        {req_write_i, req_asi_i, req_addr_i, req_valid_i} = {w, asi, ad, 1'b1};
        for (i = 0; i < 400; i++)
        begin
            #1;
            if (pr ? resp_valid_o === 1'b1 : req_ready_o === 1'b1)
                break;
            @(negedge clk_i);
        end
        if (i == 400)
        begin
            fails++;
            test_done();
        end
        q = resp_data_o;
        @(negedge clk_i);
        req_valid_i = 1'b0;
        if (!pr)
            q = resp_data_o;
        @(negedge clk_i);
    endtask
    task automatic fill(input int k, input logic [31:0] va, input logic [1:0] lv, input logic [1:0] kd,
                        input logic [2:0] pm);
        {sva[k], slv[k], skd[k], spm[k], sctx[k]} = {va, lv, kd, pm, context_id_i};
        {fill_slot_i, fill_addr_i, fill_level_i, fill_paddr_i} = {3'(k), va, lv, 32'h0000_5000 + 32'(k * 4)};
        fill_entry_i = ($urandom & 32'hFFFF_FF80) | {25'h0, 2'b00, pm, kd};
        fill_valid_i = 1'b1;
        @(negedge clk_i);
        fill_valid_i = 1'b0;
        @(negedge clk_i);
    endtask
    function automatic logic [31:0] must_go(input logic [3:0] t, input logic [31:0] fa);
        logic own;
        must_go = '0;
        for (int k = 0; k < ENTRIES; k++)
        begin
            own = skd[k] == KIND_POINTER || spm[k] >= PERM_SHARED_MIN || sctx[k] == context_id_i;
            case (t)
                OP_PAGE: must_go[k] = slv[k] == 2'd3 && fa[31:12] == sva[k][31:12] && own;
                OP_SEGMENT: must_go[k] = slv[k] >= 2'd2 && fa[31:18] == sva[k][31:18] && own;
                OP_REGION: must_go[k] = slv[k] >= 2'd1 && fa[31:24] == sva[k][31:24] && own;
                OP_CONTEXT: must_go[k] = sctx[k] == context_id_i && (skd[k] == KIND_POINTER || spm[k] < 3'd6);
                OP_ENTIRE: must_go[k] = 1'b1;
                default: must_go[k] = 1'b0;
            endcase
        end
    endfunction
    task automatic upd(input logic w, input int b, input logic [1:0] exp);
        int i;
        {xlate_slot_i, xlate_write_i, xlate_valid_i} = {3'd0, w, 1'b1};
        #1;
        chk("xlate_hold", 32'h1, {31'h0, xlate_hold_o});
        @(negedge clk_i);
        xlate_valid_i = 1'b0;
        for (i = 0; i < 100 && u_pdcm_mem_model.mem[32'h0000_5000][b] !== 1'b1; i++)
            @(negedge clk_i);
        if (i == 100)
        begin
            fails++;
            test_done();
        end
        repeat (8) @(negedge clk_i);
        chk("rm_bits", {30'h0, exp}, {30'h0, u_pdcm_mem_model.mem[32'h0000_5000][6:5]});
    endtask
    // ------
    // Sequence
    // ------
    initial
    begin
        void'($urandom(72014));
        repeat (6) @(negedge clk_i);
        reset_i = 1'b0;
        @(negedge clk_i);
        chk("reset_slots", 32'h0, {24'h0, slot_valid_o});
        for (int t = 0; t < 6; t++)
        begin
            for (int k = 0; k < ENTRIES; k++)
            begin
                context_id_i = 8'($urandom_range(1, 2));
                fill(k, 32'hA500_0000 | ($urandom & 32'h0104_1000), 2'($urandom), 2'($urandom_range(1, 2)), 3'($urandom));
            end
            context_id_i = 8'h01;
            a = sva[$urandom_range(0, 7)] | (t << 8);
            go = must_go(4'(t), a);
            op(1'b1, ASI_MMU_OP, a, d);
            chk("flush_left", 32'h0, {24'h0, slot_valid_o} & go);
            if (t == 5)
                chk("reserved_kept", 32'h0000_00FF, {24'h0, slot_valid_o});
        end
        a = 32'h1234_5000;
        l1a = 32'h0000_2000 + {22'h0, a[31:24], 2'b00};
        l3a = 32'h0000_4000 + {24'h0, a[17:12], 2'b00};
        u_pdcm_mem_model.mem[32'h0000_1004] = 32'h0000_0201;
        u_pdcm_mem_model.mem[l1a] = 32'h0000_0301;
        u_pdcm_mem_model.mem[32'h0000_3000 + {24'h0, a[23:18], 2'b00}] = 32'h0000_0401;
        u_pdcm_mem_model.mem[l3a] = 32'h0ABC_DE6A;
        pexp = '{32'h0ABC_DE6A, 32'h0000_0401, 32'h0000_0301, 32'h0000_0201, 32'h0ABC_DE6A, 32'h0};
        for (int t = 0; t < 6; t++)
        begin
            slow = t[0];
            op(1'b0, ASI_MMU_OP, a | (t << 8), d);
            chk("probe", pexp[t], d);
        end
        for (int f = 1; f < 4; f++)
        begin
            fault_sel = 2'(f);
            op(1'b0, ASI_MMU_OP, a | 32'h0000_0400, d);
            chk("probe_fault", 32'h0, d);
        end
        fault_sel = 2'b00;
        u_pdcm_mem_model.mem[l3a] = 32'h0000_0501;
        op(1'b0, ASI_MMU_OP, a, d);
        chk("probe_l3_pointer", 32'h0, d);
        op(1'b0, ASI_MMU_OP, a | 32'h0000_0400, d);
        chk("probe_none", 32'h0, d);
        u_pdcm_mem_model.mem[l1a] = 32'h0000_0003;
        op(1'b0, ASI_MMU_OP, a, d);
        chk("probe_reserved_mid", 32'h0, d);
        op(1'b0, ASI_DIAG_ONE, 32'h0000_001C, d);
        chk("diag_read", fill_entry_i, d);
        req_wdata_i = 32'h5A5A_0F0F;
        op(1'b1, ASI_DIAG_ALT, 32'h0000_0018, d);
        op(1'b0, ASI_DIAG_ALT, 32'h0000_0018, d);
        chk("diag_write", 32'h5A5A_0F0F, d);
        op(1'b0, 8'h10, 32'h0, d);
        chk("other_load", 32'h0, d);
        fill(0, 32'h7700_0000, 2'd3, KIND_ENTRY, 3'd1);
        u_pdcm_mem_model.mem[32'h0000_5000] = fill_entry_i;
        upd(1'b0, 5, 2'b01);
        upd(1'b1, 6, 2'b11);
        test_done();
    end
endmodule
`default_nettype wire
